// [design/dps_map.svh]
// Register addresses, field positions, reset values and encodings for the debug PC block
`ifndef DPS_MAP_SVH
`define DPS_MAP_SVH

// Register addresses in the hart's register space
`define DPS_ADDR_RESUME_PC    12'h7B1
`define DPS_ADDR_SCRATCH_1ST  12'h7B2
`define DPS_ADDR_SCRATCH_2ND  12'h7B3
`define DPS_ADDR_PRIV         12'h7C0

// Privilege word field positions
`define DPS_PRIV_PRV_LSB      0
`define DPS_PRIV_PRV_MSB      1
`define DPS_PRIV_VIRT_BIT     2

// Privilege encodings
`define DPS_PRV_USER          2'h0
`define DPS_PRV_SUPER         2'h1
`define DPS_PRV_MACHINE       2'h3

// Reset values
`define DPS_RESET_PC          32'h0000_0000
`define DPS_RESET_SCRATCH     32'h0000_0000

// Instruction length step for a plain 32-bit instruction
`define DPS_INSN_STEP         32'h0000_0004

// Entry cause codes
`define DPS_CAUSE_BREAK       3'h1
`define DPS_CAUSE_TRIGGER     3'h2
`define DPS_CAUSE_HALTREQ     3'h3
`define DPS_CAUSE_STEP        3'h4
`define DPS_CAUSE_RESETHALT   3'h5
`define DPS_CAUSE_GROUP       3'h6

// Redirect countdown start; the load pulse comes 3 cycles after the done answer of a running-write
`define DPS_REDIRECT_DELAY    2'h2

`endif

// [design/dps_pkg.sv]
// Types shared by the debug PC block files
package dps_pkg;

   // Hart run states seen by this block
   typedef enum logic [1:0] {
      DPS_RUN     = 2'b00,
      DPS_HALTED  = 2'b01,
      DPS_RESUME  = 2'b10
   } dps_mode_e;

   // Register select after address decode
   typedef enum logic [2:0] {
      DPS_SEL_NONE = 3'b000,
      DPS_SEL_PC   = 3'b001,
      DPS_SEL_S0   = 3'b010,
      DPS_SEL_S1   = 3'b011,
      DPS_SEL_PRIV = 3'b100
   } dps_sel_e;

endpackage

// [design/dps_dec_if.sv]
// Interface carrying the register access decode between top and decoder
`timescale 1ns/1ps
`default_nettype none
interface dps_dec_if;
   import dps_pkg::*;
   logic [11:0] addr;   // Register address
   logic        valid;  // Access strobe
   dps_sel_e    sel;    // Decoded selection
   logic        hit;    // Address is mapped

   modport top (output addr, output valid, input sel, input hit);
   modport dec (input addr, input valid, output sel, output hit);
endinterface
`default_nettype wire

// [design/dps_decode.sv]
// Register address decoder for the debug PC block
`timescale 1ns/1ps
`default_nettype none
`include "dps_map.svh"
module dps_decode
   import dps_pkg::*;
(
   // Decode channel
   dps_dec_if.dec bus
);

   // Pure decode, no state needed
   always_comb begin
      bus.sel = DPS_SEL_NONE;
      bus.hit = 1'b0;
      if (bus.valid) begin
         case (bus.addr)
            `DPS_ADDR_RESUME_PC: begin
               bus.sel = DPS_SEL_PC;
               bus.hit = 1'b1;
            end
            `DPS_ADDR_SCRATCH_1ST: begin
               bus.sel = DPS_SEL_S0;
               bus.hit = 1'b1;
            end
            `DPS_ADDR_SCRATCH_2ND: begin
               bus.sel = DPS_SEL_S1;
               bus.hit = 1'b1;
            end
            `DPS_ADDR_PRIV: begin
               bus.sel = DPS_SEL_PRIV;
               bus.hit = 1'b1;
            end
            default: begin
               bus.sel = DPS_SEL_NONE;
               bus.hit = 1'b0;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// [design/dps_debug_pc.sv]
// Debug resume PC, saved privilege and debug scratch registers of one hart
`timescale 1ns/1ps
`default_nettype none
`include "dps_map.svh"
module dps_debug_pc
   import dps_pkg::*;
#(
   parameter bit HAS_VIRT      = 1'b0,  // Hart supports virtualization
   parameter bit HAS_SUPER     = 1'b1,  // Hart supports supervisor mode
   parameter bit HAS_USER      = 1'b1,  // Hart supports user mode
   parameter bit COMPRESSED_OK = 1'b0   // 16-bit instruction alignment
)
(
   // Clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        nrst_in,
   // Hart pipeline status
   input  wire logic        enter_in,        // One-cycle debug entry strobe
   input  wire logic [2:0]  cause_in,        // Entry cause code
   input  wire logic [31:0] cur_pc_in,       // Address of current instruction
   input  wire logic [31:0] next_pc_in,      // Address that runs next
   input  wire logic [31:0] retired_pc_in,   // Last retired instruction
   input  wire logic [1:0]  cur_prv_in,      // Running privilege level
   input  wire logic        cur_virt_in,     // Running virtualization mode
   input  wire logic        resume_in,       // One-cycle resume strobe
   // Register access port
   input  wire logic        acc_valid_in,    // Access strobe
   input  wire logic        acc_write_in,    // 1 write, 0 read
   input  wire logic [11:0] acc_addr_in,     // Register address
   input  wire logic [31:0] acc_wdata_in,    // Write data
   input  wire logic        acc_postexec_in, // Execute-afterwards flag
   input  wire logic        progbuf_run_in,  // Program buffer running
   // Register access answer
   output logic             acc_done_out,    // One-cycle answer pulse
   output logic             acc_err_out,     // Unmapped address, with done
   output logic [31:0]      acc_rdata_out,   // Read data, with done
   // Hart control
   output logic             halted_out,      // Hart in debug mode
   output logic             pc_load_out,     // One-cycle PC load pulse
   output logic [31:0]      pc_target_out,   // Address to load into PC
   output logic [1:0]       resume_prv_out,  // Privilege after resume
   output logic             resume_virt_out  // Virtualization after resume
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   // All flops of the block in one record
   // One record keeps the reset list and the next-state copy in step;
   // a field added here needs a reset line below as well
   typedef struct packed {
      dps_mode_e   mode;        // Run state
      logic [31:0] rpc;         // Resume PC
      logic [31:0] scr0;        // First scratch
      logic [31:0] scr1;        // Second scratch
      logic [1:0]  prv;         // Saved privilege
      logic        virt;        // Saved virtualization
      logic        done;        // Answer pulse
      logic        err;         // Answer error
      logic [31:0] rdata;       // Answer data
      logic        load;        // PC load pulse
      logic [31:0] target;      // PC load address
      logic        redir_pend;  // Running write awaiting redirect
      logic [1:0]  redir_cnt;   // Redirect delay count
      logic        halted;      // Hart in debug mode, kept as a flop
   } dps_state_s;

   dps_state_s state_reg;   // Registered state
   dps_state_s state_next;  // Next state

   // Decode lives in its own module so the address map sits in one place
   dps_dec_if dec ();       // Address decode channel

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   // The strobe qualifies the decode; an idle bus selects nothing
   assign dec.addr  = acc_addr_in;
   assign dec.valid = acc_valid_in;

   dps_decode u_decode (
      .bus (dec.dec)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Clear low PC bits like the machine exception PC would
   // Bit 1 stays writable only when 16-bit instructions are allowed
   function automatic logic [31:0] dps_align(input logic [31:0] a);
      logic [31:0] r;
      r = a;
      r[0] = 1'b0;
      if (!COMPRESSED_OK) begin
         r[1] = 1'b0;
      end
      return r;
   endfunction

   // Legalise a written privilege to a supported one
   // The reserved code and any missing mode fall back to machine mode,
   // the one level that every hart has
   function automatic logic [1:0] dps_legal_prv(input logic [1:0] p);
      logic [1:0] r;
      r = `DPS_PRV_MACHINE;
      case (p)
         `DPS_PRV_USER:    r = HAS_USER ? `DPS_PRV_USER : `DPS_PRV_MACHINE;
         `DPS_PRV_SUPER:   r = HAS_SUPER ? `DPS_PRV_SUPER : `DPS_PRV_MACHINE;
         `DPS_PRV_MACHINE: r = `DPS_PRV_MACHINE;
         default:          r = `DPS_PRV_MACHINE;
      endcase
      return r;
   endfunction

   // Entry address by cause
   // A breakpoint keeps its own address so the debugger can put the
   // original instruction back; every other cause resumes at the next one
   function automatic logic [31:0] dps_entry_pc(input logic [2:0] c,
                                                input logic [31:0] cur,
                                                input logic [31:0] nxt);
      logic [31:0] r;
      r = nxt;
      case (c)
         `DPS_CAUSE_BREAK:   r = cur;
         `DPS_CAUSE_STEP:    r = nxt;
         `DPS_CAUSE_HALTREQ: r = nxt;
         `DPS_CAUSE_TRIGGER: r = nxt;
         default:            r = nxt;
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      // Hold everything; pulses drop back to zero every cycle
      state_next        = state_reg;
      state_next.done   = 1'b0;
      state_next.err    = 1'b0;
      state_next.load   = 1'b0;

      // Run state machine
      case (state_reg.mode)
         DPS_RUN: begin
            if (enter_in) begin
               // Address, privilege and mode are all taken in the entry cycle
               state_next.mode = DPS_HALTED;
               state_next.rpc  = dps_align(dps_entry_pc(cause_in, cur_pc_in,
                                                        next_pc_in));
               state_next.prv  = cur_prv_in;
               state_next.virt = HAS_VIRT ? cur_virt_in : 1'b0;
               state_next.redir_pend = 1'b0;
            end
         end
         DPS_HALTED: begin
            // Program buffer may clobber the resume PC; writes during a buffer run are not blocked
            // A resume during a buffer run is dropped, not held for later
            if (resume_in && !progbuf_run_in) begin
               state_next.mode = DPS_RESUME;
            end
         end
         DPS_RESUME: begin
            // One settling cycle, then the load leaves with the saved PC
            state_next.mode   = DPS_RUN;
            state_next.load   = 1'b1;
            state_next.target = state_reg.rpc;
         end
         default: begin
            state_next.mode = DPS_RUN;
         end
      endcase

      // Delayed redirect after a running write
      // A fixed short delay stands in for a fetch boundary; a debug entry
      // in the meantime drops the pending redirect
      if (state_reg.redir_pend && state_reg.mode == DPS_RUN && !enter_in) begin
         if (state_reg.redir_cnt == 2'h0) begin
            state_next.redir_pend = 1'b0;
            state_next.load       = 1'b1;
            state_next.target     = state_reg.rpc;
         end else begin
            state_next.redir_cnt = state_reg.redir_cnt - 2'h1;
         end
      end

      // Register accesses; entry capture wins over a same-cycle write
      // Every strobe is answered one cycle later, mapped or not, so the
      // debug module never waits on an address that is not there
      if (acc_valid_in) begin
         state_next.done  = 1'b1;
         state_next.err   = !dec.hit;
         state_next.rdata = 32'h0000_0000;
         case (dec.sel)
            DPS_SEL_PC: begin
               // Running reads show the last retired instruction
               state_next.rdata = (state_reg.mode == DPS_RUN) ?
                                  retired_pc_in : state_reg.rpc;
               if (acc_write_in && !(enter_in && state_reg.mode == DPS_RUN)) begin
                  state_next.rpc = dps_align(acc_wdata_in);
                  if (state_reg.mode == DPS_RUN) begin
                     state_next.redir_pend = 1'b1;
                     state_next.redir_cnt  = `DPS_REDIRECT_DELAY;
                  end
               end
               // Postexec flag never blocks this access
               if (acc_postexec_in) begin
                  state_next.err = 1'b0;
               end
            end
            DPS_SEL_S0: begin
               state_next.rdata = state_reg.scr0;
               if (acc_write_in) begin
                  state_next.scr0 = acc_wdata_in;
               end
            end
            DPS_SEL_S1: begin
               state_next.rdata = state_reg.scr1;
               if (acc_write_in) begin
                  state_next.scr1 = acc_wdata_in;
               end
            end
            DPS_SEL_PRIV: begin
               state_next.rdata[`DPS_PRIV_PRV_MSB:`DPS_PRIV_PRV_LSB] = state_reg.prv;
               state_next.rdata[`DPS_PRIV_VIRT_BIT] = state_reg.virt;
               // Only effective while halted, so entry capture is not disturbed
               if (acc_write_in && state_reg.mode == DPS_HALTED) begin
                  state_next.prv = dps_legal_prv(
                     acc_wdata_in[`DPS_PRIV_PRV_MSB:`DPS_PRIV_PRV_LSB]);
                  state_next.virt = HAS_VIRT &&
                     acc_wdata_in[`DPS_PRIV_VIRT_BIT] &&
                     (dps_legal_prv(acc_wdata_in[1:0]) != `DPS_PRV_MACHINE);
               end
            end
            default: begin
               state_next.rdata = 32'h0000_0000;
            end
         endcase
      end

      // Halted and resuming both count as debug mode for the hart
      // Registered here so the output needs no logic after the flop
      state_next.halted = (state_next.mode != DPS_RUN);
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   // Reset loads constants only; the hart comes up running in machine mode
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_reg.mode       <= DPS_RUN;
         state_reg.rpc        <= `DPS_RESET_PC;
         state_reg.scr0       <= `DPS_RESET_SCRATCH;
         state_reg.scr1       <= `DPS_RESET_SCRATCH;
         state_reg.prv        <= `DPS_PRV_MACHINE;
         state_reg.virt       <= 1'b0;
         state_reg.done       <= 1'b0;
         state_reg.err        <= 1'b0;
         state_reg.rdata      <= 32'h0000_0000;
         state_reg.load       <= 1'b0;
         state_reg.target     <= `DPS_RESET_PC;
         state_reg.redir_pend <= 1'b0;
         state_reg.redir_cnt  <= 2'h0;
         state_reg.halted     <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from flops

   assign acc_done_out    = state_reg.done;
   assign acc_err_out     = state_reg.err;
   assign acc_rdata_out   = state_reg.rdata;
   // Debug mode flag has its own flop rather than a compare on the state
   assign halted_out      = state_reg.halted;
   assign pc_load_out     = state_reg.load;
   assign pc_target_out   = state_reg.target;
   assign resume_prv_out  = state_reg.prv;
   assign resume_virt_out = state_reg.virt;

endmodule
`default_nettype wire

// [tb/dps_checker.sv]
// Port assertions for the debug PC block
`timescale 1ns/1ps
`default_nettype none
module dps_checker (
   // Clock and reset
   input wire logic        core_clk_in,
   input wire logic        nrst_in,
   // Hart and access inputs
   input wire logic        enter_in,
   input wire logic [1:0]  cur_prv_in,
   input wire logic        resume_in,
   input wire logic        acc_valid_in,
   input wire logic [11:0] acc_addr_in,
   input wire logic        progbuf_run_in,
   // Block outputs
   input wire logic        acc_done_out,
   input wire logic        acc_err_out,
   input wire logic        halted_out,
   input wire logic        pc_load_out,
   input wire logic [31:0] pc_target_out,
   input wire logic [1:0]  resume_prv_out,
   input wire logic        resume_virt_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   ////////////////////////////////////////////////////////////////////////////////
   logic mapped;  // Address hits one of the four registers
   assign mapped = acc_addr_in inside {12'h7B1, 12'h7B2, 12'h7B3, 12'h7C0};
   // Accepted resume: halted, buffer idle
   sequence s_resume;
      resume_in && halted_out && !progbuf_run_in && !pc_load_out;
   endsequence
   // One quiet cycle, then the load with the hart running
   sequence s_load;
      ##1 !pc_load_out ##1 (pc_load_out && !halted_out);
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   a_done_one_cycle: assert property (acc_done_out == $past(acc_valid_in))
      else $error("done not one cycle after access");
   a_err_unmapped: assert property (acc_valid_in && !mapped |=> acc_err_out)
      else $error("unmapped access without error");
   a_err_mapped: assert property (acc_valid_in && mapped |=> !acc_err_out)
      else $error("mapped access flagged as error");
   a_halt_entry: assert property (enter_in && !halted_out |=> halted_out)
      else $error("entry did not halt");
   a_prv_record: assert property (enter_in && !halted_out && cur_prv_in != 2'h2
      |=> resume_prv_out == $past(cur_prv_in)) else $error("privilege not recorded");
   a_resume_load: assert property (s_resume |-> s_load)
      else $error("resume load missing or mistimed");
   a_load_single: assert property (pc_load_out |=> !pc_load_out)
      else $error("load pulse longer than a cycle");
   a_target_align: assert property (pc_load_out |-> pc_target_out[1:0] == 2'h0)
      else $error("load target misaligned");
   a_virt_tied: assert property (!resume_virt_out)
      else $error("virtualization bit set");
   a_prv_legal: assert property (resume_prv_out != 2'h2)
      else $error("unsupported privilege kept");
endmodule
bind dps_debug_pc dps_checker dps_checker_i (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
   .enter_in(enter_in), .cur_prv_in(cur_prv_in), .resume_in(resume_in),
   .acc_valid_in(acc_valid_in), .acc_addr_in(acc_addr_in), .progbuf_run_in(progbuf_run_in),
   .acc_done_out(acc_done_out), .acc_err_out(acc_err_out), .halted_out(halted_out),
   .pc_load_out(pc_load_out), .pc_target_out(pc_target_out),
   .resume_prv_out(resume_prv_out), .resume_virt_out(resume_virt_out));
`default_nettype wire

// [tb/dps_dm_model.sv]
// Debug module model issuing register accesses and buffer runs
`timescale 1ns/1ps
`default_nettype none
module dps_dm_model #(
   parameter bit SCRATCH_DECLARED = 1'b1  // Hart info frees both scratch words
) (
   // Clock and answer
   input  wire logic        core_clk_in,
   input  wire logic        done_in,
   input  wire logic        err_in,
   input  wire logic [31:0] rdata_in,
   // Access request
   output logic             valid_out,
   output logic             write_out,
   output logic [11:0]      addr_out,
   output logic [31:0]      wdata_out,
   output logic             postexec_out,
   output logic             progbuf_out
);
   logic [31:0] saved_pc;  // Resume PC kept across a buffer run
   initial begin
      valid_out = 1'b0;
      write_out = 1'b0;
      addr_out = 12'h000;
      wdata_out = 32'h0;
      postexec_out = 1'b0;
      progbuf_out = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // One-cycle strobe, then address and data lines show inverted values
   task automatic access(input logic w, input logic p, input logic [11:0] a,
                         input logic [31:0] d, output logic [31:0] q, output logic e,
                         output bit ok);
      ok = 1'b0;
      if (w && !SCRATCH_DECLARED && a inside {12'h7B2, 12'h7B3}) return;
      @(posedge core_clk_in);
      valid_out <= 1'b1;
      write_out <= w;
      postexec_out <= p;
      addr_out <= a;
      wdata_out <= d;
      @(posedge core_clk_in);
      valid_out <= 1'b0;
      addr_out <= ~a;
      wdata_out <= ~d;
      for (int i = 0; i < 8 && !ok; i++) begin
         @(posedge core_clk_in);
         q = rdata_in;
         e = err_in;
         ok = (done_in === 1'b1);
      end
   endtask
   // Save resume PC, run the buffer, restore before any resume
   task automatic run_progbuf(output bit ok);
      logic [31:0] q;
      logic        e;
      access(1'b0, 1'b1, 12'h7B1, 32'h0, saved_pc, e, ok);
      if (!ok) return;
      progbuf_out <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      progbuf_out <= 1'b0;
      access(1'b1, 1'b0, 12'h7B1, saved_pc, q, e, ok);
   endtask
endmodule
`default_nettype wire

// [tb/dps_debug_pc_test.sv]
// Self-checking bench for the debug PC block
`timescale 1ns/1ps
`default_nettype none
module dps_debug_pc_test;
   // Bench-driven inputs
   logic        core_clk_in, nrst_in, enter_in, resume_in, cur_virt_in;
   logic [2:0]  cause_in;
   logic [1:0]  cur_prv_in;
   logic [31:0] cur_pc_in, next_pc_in, retired_pc_in;
   // Access channel and outputs
   logic        valid, write, postexec, progbuf, done, err, halted, load, virt;
   logic [11:0] addr;
   logic [31:0] wdata, rdata, target, q;
   logic [1:0]  rprv;
   logic        e;
   bit          ok;
   int          error_cnt, n_checks;
   dps_debug_pc dps_debug_pc_i (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
      .enter_in(enter_in), .cause_in(cause_in), .cur_pc_in(cur_pc_in),
      .next_pc_in(next_pc_in), .retired_pc_in(retired_pc_in), .cur_prv_in(cur_prv_in),
      .cur_virt_in(cur_virt_in), .resume_in(resume_in), .acc_valid_in(valid),
      .acc_write_in(write), .acc_addr_in(addr), .acc_wdata_in(wdata),
      .acc_postexec_in(postexec), .progbuf_run_in(progbuf), .acc_done_out(done),
      .acc_err_out(err), .acc_rdata_out(rdata), .halted_out(halted), .pc_load_out(load),
      .pc_target_out(target), .resume_prv_out(rprv), .resume_virt_out(virt));
   dps_dm_model dm_i (.core_clk_in(core_clk_in), .done_in(done), .err_in(err),
      .rdata_in(rdata), .valid_out(valid), .write_out(write), .addr_out(addr),
      .wdata_out(wdata), .postexec_out(postexec), .progbuf_out(progbuf));
   initial begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // A wait that ran out ends the run
   task automatic need(input bit good);
      if (!good) begin
         error_cnt++;
         $display("unexpected at %0t: no answer", $time);
         end_of_test();
      end
   endtask
   task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic exp_err);
      dm_i.access(w, 1'b0, a, d, q, e, ok);
      need(ok);
      check({31'h0, e}, {31'h0, exp_err});
      if (!w) check(q, exp);
   endtask
   task automatic enter(input logic [2:0] c, input logic [31:0] cur, input logic [31:0] nxt,
                        input logic [1:0] p);
      @(posedge core_clk_in);
      enter_in <= 1'b1;
      cause_in <= c;
      cur_pc_in <= cur;
      next_pc_in <= nxt;
      cur_prv_in <= p;
      @(posedge core_clk_in);
      enter_in <= 1'b0;
      cur_pc_in <= ~cur;
      next_pc_in <= ~nxt;
      @(posedge core_clk_in);
      check({31'h0, halted}, 32'h1);
   endtask
   // Load pulse within a few cycles, hart running again
   task automatic wait_load(input logic [31:0] exp);
      ok = 1'b0;
      for (int i = 0; i < 8 && !ok; i++) begin
         @(posedge core_clk_in);
         ok = (load === 1'b1);
      end
      need(ok);
      check(target, exp);
      check({31'h0, halted}, 32'h0);
   endtask
   task automatic resume(input logic [31:0] exp);
      @(posedge core_clk_in);
      resume_in <= 1'b1;
      @(posedge core_clk_in);
      resume_in <= 1'b0;
      wait_load(exp);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {nrst_in, enter_in, resume_in, cur_virt_in, cause_in, cur_prv_in} = '0;
      {cur_pc_in, next_pc_in} = '0;
      retired_pc_in = 32'h0000_0050;
      repeat (10) @(posedge core_clk_in);
      nrst_in <= 1'b1;
      check({30'h0, rprv}, 32'h3);
      rw(1'b0, 12'h7B1, 32'h0, 32'h0000_0050, 1'b0);
      $display("test reset and running read done");
      enter(3'h1, 32'h0000_0100, 32'h0000_0104, 2'h1);
      rw(1'b0, 12'h7B1, 32'h0, 32'h0000_0100, 1'b0);
      rw(1'b0, 12'h7C0, 32'h0, 32'h0000_0001, 1'b0);
      rw(1'b1, 12'h7C0, 32'h0000_0006, 32'h0, 1'b0);
      rw(1'b0, 12'h7C0, 32'h0, 32'h0000_0003, 1'b0);
      rw(1'b1, 12'h7C0, 32'h0000_0000, 32'h0, 1'b0);
      rw(1'b1, 12'h7B1, 32'h0000_0203, 32'h0, 1'b0);
      rw(1'b0, 12'h7B1, 32'h0, 32'h0000_0200, 1'b0);
      rw(1'b1, 12'h7B2, 32'hA5A5_0001, 32'h0, 1'b0);
      rw(1'b1, 12'h7B3, 32'h5A5A_0002, 32'h0, 1'b0);
      rw(1'b0, 12'h7B2, 32'h0, 32'hA5A5_0001, 1'b0);
      rw(1'b0, 12'h7B3, 32'h0, 32'h5A5A_0002, 1'b0);
      rw(1'b0, 12'h7B4, 32'h0, 32'h0000_0000, 1'b1);
      // Resume attempt while the buffer runs must be refused
      fork
         dm_i.run_progbuf(ok);
         begin
            for (int i = 0; i < 20 && progbuf !== 1'b1; i++) @(posedge core_clk_in);
            need(progbuf === 1'b1);
            resume_in <= 1'b1;
            @(posedge core_clk_in);
            resume_in <= 1'b0;
         end
      join
      need(ok);
      check({31'h0, halted}, 32'h1);
      check(dm_i.saved_pc, 32'h0000_0200);
      rw(1'b0, 12'h7B1, 32'h0, 32'h0000_0200, 1'b0);
      resume(32'h0000_0200);
      check({30'h0, rprv}, 32'h0);
      $display("test breakpoint halt and resume done");
      cur_virt_in <= 1'b1;
      for (int c = 2; c <= 6; c++) begin
         enter(c[2:0], 32'h0000_1000, 32'h0000_2000 + 32'(c * 16), 2'h3);
         check({31'h0, virt}, 32'h0);
         rw(1'b0, 12'h7B1, 32'h0, 32'h0000_2000 + 32'(c * 16), 1'b0);
         resume(32'h0000_2000 + 32'(c * 16));
      end
      $display("test entry causes done");
      rw(1'b1, 12'h7B1, 32'h0000_3000, 32'h0, 1'b0);
      wait_load(32'h0000_3000);
      $display("test running redirect done");
      end_of_test();
   end
endmodule
`default_nettype wire
